/* File: design/pin_mux_pkg.sv */
package pin_mux_pkg;
  localparam int PORT_THREE_W = 16;
  localparam int PORT_FOUR_W = 2;
  localparam int CFG_W = 2;
  localparam int ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_THREE_LATCH = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_THREE_DIR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_FOUR_LATCH = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_FOUR_DIR = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_SYS_CONFIG = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_THREE_PINS = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_FOUR_PINS = 5'h18;

  // Reset values
  localparam logic [PORT_THREE_W-1:0] THREE_RESET = 16'h0000;
  localparam logic [PORT_FOUR_W-1:0] FOUR_RESET = 2'h0;
  localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;

  // System configuration fields
  localparam int CFG_BYTE_HIGH_DISABLE = 0;
  localparam int CFG_SEGMENTATION_DISABLE = 1;

  // Port three line positions
  localparam int BIT_TIMER0_IN = 0;
  localparam int BIT_TIMER6_OUT = 1;
  localparam int BIT_SERIAL1_RX = 9;
  localparam int BIT_BYTE_HIGH = 12;
  localparam int BIT_READY = 14;
  // Lines 0,2,4,5,6,7,14 take alternate input only
  localparam logic [PORT_THREE_W-1:0] ALT_IN_ONLY = 16'h40F5;
  // Lines 1,3,8,10,13,15 plus receive lines 9,11 AND the latch
  localparam logic [PORT_THREE_W-1:0] ALT_AND_MASK = 16'hAF0A;

  // Bus configuration pin encodings
  localparam logic [1:0] BUS_SINGLE_CHIP = 2'h0;
  localparam logic [1:0] BUS_MUX_8 = 2'h1;
  localparam logic [1:0] BUS_MUX_16 = 2'h2;
  localparam logic [1:0] BUS_DEMUX_16 = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [PORT_THREE_W-1:0] level;
    logic [PORT_THREE_W-1:0] in_use;
  } alt_drive_t;

  typedef struct packed {
    logic byte_high_enable_n;
    logic segment_address_high;
    logic segment_address_low;
  } bus_drive_t;
endpackage : pin_mux_pkg

/* File: design/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pin_sync

/* File: design/alt_pin_mux.sv */
// Functional notes
// [R1] Every port three line has alternate function
// [R2] Unused alternate lines act as GPIO
// [R3] Input-only alternates read the input latch
// [R4] Software sets input when pin driven externally
// [R5] Output direction loops latch into input latch
// [R6] Ready line also offers unlatched pin input
// [R7] Lines 1,3,13,15 carry timer/strobe/clock outputs
// [R8] Lines 10,8 carry serial transmit or clock
// [R9] Alternate output ANDed with port latch
// [R10] Software sets output and latch one first
// [R11] Idle alternate output rests high
// [R12] Sixteen-bit bus forces line 12 byte-high output
// [R13] Byte-high disable returns line 12 to GPIO
// [R14] Async serial: software sets receive lines input
// [R15] Half-duplex: software flips receive line direction
// [R16] Port four carries segment address low/high
// [R17] External bus drives segment address on four
// [R18] Segmentation disable returns port four to GPIO
// [R19] All directions reset to input
// [R20] Released lines use last written direction
// [R21] Writes stored during automatic control
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module alt_pin_mux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic bus_config_pin_1,
  input wire logic bus_config_pin_0,
  input wire pin_mux_pkg::alt_drive_t alt_drive,
  input wire pin_mux_pkg::bus_drive_t bus_drive,
  input wire logic [pin_mux_pkg::PORT_THREE_W-1:0] port_three_in,
  output logic [pin_mux_pkg::PORT_THREE_W-1:0] port_three_out,
  output logic [pin_mux_pkg::PORT_THREE_W-1:0] port_three_oe,
  input wire logic [pin_mux_pkg::PORT_FOUR_W-1:0] port_four_in,
  output logic [pin_mux_pkg::PORT_FOUR_W-1:0] port_four_out,
  output logic [pin_mux_pkg::PORT_FOUR_W-1:0] port_four_oe,
  output logic [pin_mux_pkg::PORT_THREE_W-1:0] alt_input,
  output logic ready_unlatched_n
);
  localparam int SYNC_W = pin_mux_pkg::PORT_THREE_W + pin_mux_pkg::PORT_FOUR_W + 2;
  localparam int F_LO = pin_mux_pkg::PORT_THREE_W;
  localparam int C_LO = F_LO + pin_mux_pkg::PORT_FOUR_W;

  logic [pin_mux_pkg::PORT_THREE_W-1:0] three_latch;
  logic [pin_mux_pkg::PORT_THREE_W-1:0] three_dir;
  logic [pin_mux_pkg::PORT_FOUR_W-1:0] four_latch;
  logic [pin_mux_pkg::PORT_FOUR_W-1:0] four_dir;
  logic [pin_mux_pkg::PORT_FOUR_W-1:0] four_pins;
  logic [pin_mux_pkg::CFG_W-1:0] sys_config;
  logic [SYNC_W-1:0] sync_q;
  logic [pin_mux_pkg::PORT_THREE_W-1:0] s_three;
  logic [pin_mux_pkg::PORT_FOUR_W-1:0] s_four;
  logic [1:0] s_cfg;
  logic external_bus;
  logic sixteen_bit;
  logic bhe_auto;
  logic seg_auto;
  logic [pin_mux_pkg::PORT_THREE_W-1:0] alt_level;
  logic [pin_mux_pkg::PORT_THREE_W-1:0] next_three_out;
  logic [pin_mux_pkg::PORT_THREE_W-1:0] next_three_oe;
  logic [pin_mux_pkg::ADDR_W-1:0] aw_addr_q;
  logic [pin_mux_pkg::ADDR_W-1:0] ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [pin_mux_pkg::ADDR_W-1:0] wr_word;
  logic [pin_mux_pkg::ADDR_W-1:0] rd_word;
  logic do_write;
  logic do_read;

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic is_mapped(input logic [pin_mux_pkg::ADDR_W-1:0] a);
    case (a)
      pin_mux_pkg::OFS_THREE_LATCH, pin_mux_pkg::OFS_THREE_DIR,
      pin_mux_pkg::OFS_FOUR_LATCH, pin_mux_pkg::OFS_FOUR_DIR,
      pin_mux_pkg::OFS_SYS_CONFIG, pin_mux_pkg::OFS_THREE_PINS,
      pin_mux_pkg::OFS_FOUR_PINS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Pins and bus configuration straps cross in from outside
  pin_sync #(
    .W(SYNC_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({bus_config_pin_1, bus_config_pin_0, port_four_in, port_three_in}),
    .q(sync_q)
  );

  assign s_three = sync_q[F_LO-1:0];
  assign s_four = sync_q[C_LO-1:F_LO];
  assign s_cfg = sync_q[SYNC_W-1:C_LO];
  assign ready_unlatched_n = sync_q[pin_mux_pkg::BIT_READY]; // R6

  assign external_bus = s_cfg != pin_mux_pkg::BUS_SINGLE_CHIP;
  assign sixteen_bit = (s_cfg == pin_mux_pkg::BUS_MUX_16) || (s_cfg == pin_mux_pkg::BUS_DEMUX_16);
  assign bhe_auto = sixteen_bit && !sys_config[pin_mux_pkg::CFG_BYTE_HIGH_DISABLE]; // R12 R13
  assign seg_auto = external_bus && !sys_config[pin_mux_pkg::CFG_SEGMENTATION_DISABLE]; // R17 R18

  // Per-line output path; line 12 is the only automatic one
  for (genvar i = 0; i < pin_mux_pkg::PORT_THREE_W; i++) begin : g_three
    // A peripheral not using its line reads as high
    assign alt_level[i] = (pin_mux_pkg::ALT_AND_MASK[i] && alt_drive.in_use[i]) ?
                          alt_drive.level[i] : 1'b1; // R11 R7 R8
    if (i == pin_mux_pkg::BIT_BYTE_HIGH) begin : g_bhe
      assign next_three_out[i] = bhe_auto ? bus_drive.byte_high_enable_n : three_latch[i]; // R12
      assign next_three_oe[i] = bhe_auto | three_dir[i]; // R13 R20
    end else begin : g_gp
      assign next_three_out[i] = three_latch[i] & alt_level[i]; // R9 R1
      assign next_three_oe[i] = three_dir[i]; // R2
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_three_out <= pin_mux_pkg::THREE_RESET;
      port_three_oe <= pin_mux_pkg::THREE_RESET;
    end else begin
      port_three_out <= next_three_out;
      port_three_oe <= next_three_oe;
    end
  end

  // Segment address bypasses the latch so software's value survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_four_out <= pin_mux_pkg::FOUR_RESET;
      port_four_oe <= pin_mux_pkg::FOUR_RESET;
    end else if (seg_auto) begin
      port_four_out <= {bus_drive.segment_address_high, bus_drive.segment_address_low}; // R16 R17
      port_four_oe <= '1; // R17
    end else begin
      port_four_out <= four_latch; // R18
      port_four_oe <= four_dir; // R18 R20
    end
  end

  // Input latch sees the driven value while a line is an output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_input <= pin_mux_pkg::THREE_RESET;
      four_pins <= pin_mux_pkg::FOUR_RESET;
    end else begin
      alt_input <= (port_three_oe & port_three_out) | (~port_three_oe & s_three); // R3 R5
      four_pins <= (port_four_oe & port_four_out) | (~port_four_oe & s_four);
    end
  end

  // Write path: address and data held until both are in
  assign do_write = !awready && !wready && !bvalid;
  assign wr_word = {aw_addr_q[pin_mux_pkg::ADDR_W-1:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= pin_mux_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(wr_word) ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Software values stay stored even while hardware owns a line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      three_latch <= pin_mux_pkg::THREE_RESET;
      three_dir <= pin_mux_pkg::THREE_RESET; // R19
      four_latch <= pin_mux_pkg::FOUR_RESET;
      four_dir <= pin_mux_pkg::FOUR_RESET; // R19
      sys_config <= pin_mux_pkg::CFG_RESET;
    end else if (do_write) begin
      case (wr_word)
        pin_mux_pkg::OFS_THREE_LATCH: three_latch <= merge16(three_latch, w_data_q, w_strb_q);
        pin_mux_pkg::OFS_THREE_DIR: three_dir <= merge16(three_dir, w_data_q, w_strb_q); // R21
        pin_mux_pkg::OFS_FOUR_LATCH: begin
          if (w_strb_q[0]) begin
            four_latch <= w_data_q[pin_mux_pkg::PORT_FOUR_W-1:0]; // R21
          end
        end
        pin_mux_pkg::OFS_FOUR_DIR: begin
          if (w_strb_q[0]) begin
            four_dir <= w_data_q[pin_mux_pkg::PORT_FOUR_W-1:0]; // R21
          end
        end
        pin_mux_pkg::OFS_SYS_CONFIG: begin
          if (w_strb_q[0]) begin
            sys_config <= w_data_q[pin_mux_pkg::CFG_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read path: one cycle from address capture to data
  assign do_read = !arready && !rvalid;
  assign rd_word = {ar_addr_q[pin_mux_pkg::ADDR_W-1:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      ar_addr_q <= '0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      ar_addr_q <= araddr;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= pin_mux_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid <= 1'b1;
      rresp <= is_mapped(rd_word) ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
      case (rd_word)
        pin_mux_pkg::OFS_THREE_LATCH: rdata <= 32'(three_latch);
        pin_mux_pkg::OFS_THREE_DIR: rdata <= 32'(three_dir);
        pin_mux_pkg::OFS_FOUR_LATCH: rdata <= 32'(four_latch);
        pin_mux_pkg::OFS_FOUR_DIR: rdata <= 32'(four_dir);
        pin_mux_pkg::OFS_SYS_CONFIG: rdata <= 32'(sys_config);
        pin_mux_pkg::OFS_THREE_PINS: rdata <= 32'(alt_input);
        pin_mux_pkg::OFS_FOUR_PINS: rdata <= 32'(four_pins);
        default: rdata <= '0;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_line0_driven;
    three_dir[pin_mux_pkg::BIT_TIMER0_IN] ##1 three_dir[pin_mux_pkg::BIT_TIMER0_IN];
  endsequence

  sequence s_dir_write;
    do_write && wr_word == pin_mux_pkg::OFS_THREE_DIR && w_strb_q[1:0] == 2'h3;
  endsequence

  a_bhe_forced: assert property (bhe_auto |=> port_three_oe[pin_mux_pkg::BIT_BYTE_HIGH] && // R12
    port_three_out[pin_mux_pkg::BIT_BYTE_HIGH] == $past(bus_drive.byte_high_enable_n))
    else $error("byte-high line not forced to output");

  a_bhe_released: assert property (!bhe_auto |=> // R13
    port_three_oe[pin_mux_pkg::BIT_BYTE_HIGH] == $past(three_dir[pin_mux_pkg::BIT_BYTE_HIGH]))
    else $error("byte-high line not back under direction bit");

  a_segment_drive: assert property (seg_auto |=> port_four_oe == '1 && // R17
    port_four_out == $past({bus_drive.segment_address_high, bus_drive.segment_address_low}))
    else $error("segment address not driven on port four");

  a_segment_release: assert property (!seg_auto |=> // R18
    port_four_oe == $past(four_dir) && port_four_out == $past(four_latch))
    else $error("port four not back to general purpose");

  a_and_output: assert property (alt_drive.in_use[pin_mux_pkg::BIT_TIMER6_OUT] |=> // R9
    port_three_out[pin_mux_pkg::BIT_TIMER6_OUT] ==
    $past(three_latch[pin_mux_pkg::BIT_TIMER6_OUT] & alt_drive.level[pin_mux_pkg::BIT_TIMER6_OUT]))
    else $error("alternate output not ANDed with latch");

  a_idle_rest_high: assert property (!alt_drive.in_use[pin_mux_pkg::BIT_SERIAL1_RX] |=> // R11
    port_three_out[pin_mux_pkg::BIT_SERIAL1_RX] == $past(three_latch[pin_mux_pkg::BIT_SERIAL1_RX]))
    else $error("idle alternate output does not follow latch");

  a_latch_loopback: assert property (s_line0_driven |=> // R5
    alt_input[pin_mux_pkg::BIT_TIMER0_IN] == $past(three_latch[pin_mux_pkg::BIT_TIMER0_IN], 2))
    else $error("input latch does not reflect output latch");

  a_ready_input: assert property (!port_three_oe[pin_mux_pkg::BIT_READY] |=> // R3 R6
    alt_input[pin_mux_pkg::BIT_READY] == $past(ready_unlatched_n))
    else $error("input latch does not follow ready pin");

  a_reset_input: assert property ($past(aresetn) == 1'b0 |-> // R19
    three_dir == pin_mux_pkg::THREE_RESET && four_dir == pin_mux_pkg::FOUR_RESET &&
    port_three_oe == pin_mux_pkg::THREE_RESET)
    else $error("direction not input after reset");

  a_write_stored: assert property (s_dir_write |=> three_dir == $past(w_data_q[15:0])) // R21
    else $error("direction write not stored");

endmodule : alt_pin_mux

/* File: tb/periph_model.sv */
`timescale 1ns/1ps
module periph_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] use_req,
  input wire logic [15:0] lvl_req,
  input wire logic [2:0] bus_req,
  output pin_mux_pkg::alt_drive_t alt_drive,
  output pin_mux_pkg::bus_drive_t bus_drive
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_drive <= {16'hFFFF, 16'h0000};
      bus_drive <= 3'h7;
    end else begin
      // Idle units rest high so the pin just follows the latch
      alt_drive.level <= lvl_req | ~use_req;
      alt_drive.in_use <= use_req;
      bus_drive <= bus_req;
    end
  end
endmodule : periph_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rdy_n;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, mode, cfg;
  logic [15:0] use_q, lvl_q, o3, oe3, ai, ext3, pin3, lat3, dir3, x3out, x3oe, x3p;
  logic [1:0] o4, oe4, ext4, pin4, lat4, dir4, x4out, x4oe, x4p;
  logic [2:0] bus_q;
  int err_count, total_checks, cyc;
  pin_mux_pkg::alt_drive_t alt;
  pin_mux_pkg::bus_drive_t bus;
  // Outside parties only drive where the port is not driving
  assign pin3 = (oe3 & o3) | (~oe3 & ext3);
  assign pin4 = (oe4 & o4) | (~oe4 & ext4);

  alt_pin_mux u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bus_config_pin_1(mode[1]), .bus_config_pin_0(mode[0]), .alt_drive(alt),
    .bus_drive(bus), .port_three_in(pin3), .port_three_out(o3), .port_three_oe(oe3),
    .port_four_in(pin4), .port_four_out(o4), .port_four_oe(oe4), .alt_input(ai),
    .ready_unlatched_n(rdy_n));

  periph_model u_periph (.aclk(aclk), .aresetn(aresetn), .use_req(use_q), .lvl_req(lvl_q),
    .bus_req(bus_q), .alt_drive(alt), .bus_drive(bus));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_resp

  // Level seen on a line: own driver wins, else the outside party
  function automatic logic [15:0] pin_level(input logic [15:0] oe, input logic [15:0] drv,
      input logic [15:0] ext);
    return (oe & drv) | (~oe & ext);
  endfunction : pin_level

  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_resp("bresp", er, bresp);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] ev, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", ev, rdata);
    chk_resp("rresp", er, rresp);
  endtask : rd

  task automatic check_pins;
    logic [15:0] lv;
    repeat (6) @(posedge aclk);
    lv = lvl_q | ~use_q;
    x3out = lat3 & (lv | ~pin_mux_pkg::ALT_AND_MASK);
    x3oe = dir3;
    x4out = lat4;
    x4oe = dir4;
    if ((mode == pin_mux_pkg::BUS_MUX_16 || mode == pin_mux_pkg::BUS_DEMUX_16)
        && !cfg[pin_mux_pkg::CFG_BYTE_HIGH_DISABLE]) begin
      x3out[12] = bus_q[2];
      x3oe[12] = 1'b1;
    end
    if (mode != pin_mux_pkg::BUS_SINGLE_CHIP && !cfg[pin_mux_pkg::CFG_SEGMENTATION_DISABLE]) begin
      x4out = bus_q[1:0];
      x4oe = 2'h3;
    end
    x3p = pin_level(x3oe, x3out, ext3);
    x4p = 2'(pin_level(16'(x4oe), 16'(x4out), 16'(ext4)));
    chk("port_three_out", {16'h0, x3out}, {16'h0, o3});
    chk("port_three_oe", {16'h0, x3oe}, {16'h0, oe3});
    chk("port_four_out", {30'h0, x4out}, {30'h0, o4});
    chk("port_four_oe", {30'h0, x4oe}, {30'h0, oe4});
    chk("alt_input", {16'h0, x3p}, {16'h0, ai});
    chk("ready_unlatched_n", {31'h0, x3p[14]}, {31'h0, rdy_n});
    rd(pin_mux_pkg::OFS_THREE_LATCH, {16'h0, lat3}, pin_mux_pkg::RESP_OKAY);
    rd(pin_mux_pkg::OFS_THREE_DIR, {16'h0, dir3}, pin_mux_pkg::RESP_OKAY);
    rd(pin_mux_pkg::OFS_FOUR_LATCH, {30'h0, lat4}, pin_mux_pkg::RESP_OKAY);
    rd(pin_mux_pkg::OFS_FOUR_DIR, {30'h0, dir4}, pin_mux_pkg::RESP_OKAY);
    rd(pin_mux_pkg::OFS_SYS_CONFIG, {30'h0, cfg}, pin_mux_pkg::RESP_OKAY);
    rd(pin_mux_pkg::OFS_THREE_PINS, {16'h0, x3p}, pin_mux_pkg::RESP_OKAY);
    rd(pin_mux_pkg::OFS_FOUR_PINS, {30'h0, x4p}, pin_mux_pkg::RESP_OKAY);
  endtask : check_pins

  // Random port setup and peripheral levels with the given mode and config, then program the registers
  task automatic step(input logic [1:0] m, input logic [1:0] c, input bit all);
    if (all) begin
      seed = lfsr(seed);
      lat3 = seed[15:0];
      dir3 = seed[31:16];
      seed = lfsr(seed);
      use_q <= seed[15:0];
      lvl_q <= seed[31:16];
      seed = lfsr(seed);
      lat4 = seed[1:0];
      dir4 = seed[3:2];
      bus_q <= seed[6:4];
      ext4 <= seed[8:7];
      ext3 <= seed[31:16];
    end
    mode <= m;
    cfg = c;
    if (all) begin
      wr(pin_mux_pkg::OFS_THREE_LATCH, {16'h0, lat3}, pin_mux_pkg::RESP_OKAY);
      wr(pin_mux_pkg::OFS_THREE_DIR, {16'h0, dir3}, pin_mux_pkg::RESP_OKAY);
      wr(pin_mux_pkg::OFS_FOUR_LATCH, {30'h0, lat4}, pin_mux_pkg::RESP_OKAY);
      wr(pin_mux_pkg::OFS_FOUR_DIR, {30'h0, dir4}, pin_mux_pkg::RESP_OKAY);
    end
    wr(pin_mux_pkg::OFS_SYS_CONFIG, {30'h0, cfg}, pin_mux_pkg::RESP_OKAY);
  endtask : step

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      $display("ERROR timeout expected 0 seen 1");
      summarize();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, mode, cfg, ext3, ext4, lat3, dir3, lat4, dir4, use_q, lvl_q} = '0;
    wstrb = 4'hF;
    bus_q = 3'h7;
    seed = 32'h00000005;
    err_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check_pins();
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      step(2'(i), 2'(i >> 2), 1'b1);
      check_pins();
      $display("test random %0d done", i);
    end
    // Auto control, then release without rewriting the ports
    step(pin_mux_pkg::BUS_DEMUX_16, 2'h0, 1'b1);
    check_pins();
    step(pin_mux_pkg::BUS_DEMUX_16, 2'h3, 1'b0);
    check_pins();
    $display("test release done");
    wr(5'h1C, 32'hFFFFFFFF, pin_mux_pkg::RESP_SLVERR);
    rd(5'h1C, 32'h0, pin_mux_pkg::RESP_SLVERR);
    wr(pin_mux_pkg::OFS_THREE_PINS, 32'h0000FFFF, pin_mux_pkg::RESP_OKAY);
    check_pins();
    $display("test unmapped done");
    // Single byte lane: only the low half of the latch may change
    seed = lfsr(seed);
    wstrb <= 4'h1;
    wr(pin_mux_pkg::OFS_THREE_LATCH, seed, pin_mux_pkg::RESP_OKAY);
    lat3[7:0] = seed[7:0];
    wstrb <= 4'hF;
    check_pins();
    $display("test strobe done");
    summarize();
  end
endmodule : tb_top
